// >>> verilog/acr_consts.svh
// Timing counts and widths of the conversion and readout sequencer
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH
`define ACR_BITS           16
`define ACR_CLK_NS         5
`define ACR_CONV_MAX_NS    1250
`define ACR_CONV_MARGIN_NS 50
`define ACR_CONV_CYC  ((`ACR_CONV_MAX_NS - `ACR_CONV_MARGIN_NS) / `ACR_CLK_NS)
`define ACR_FRAME_CYC (`ACR_CONV_MAX_NS / `ACR_CLK_NS)
`define ACR_DVB_NS         12
`define ACR_DVB_CYC   ((`ACR_DVB_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_END_NS         25
`define ACR_END_CYC   (`ACR_END_NS / `ACR_CLK_NS)
`define ACR_PER0_NS        30
`define ACR_PER1_NS        60
`define ACR_PER2_NS        120
`define ACR_PER3_NS        240
`define ACR_HALF(p)   ((p) / `ACR_CLK_NS / 2)
`define ACR_LEAD0_NS       3
`define ACR_LEADN_NS       17
`define ACR_TAIL0_NS       3
`define ACR_TAIL1_NS       55
`define ACR_TAIL2_NS       130
`define ACR_TAIL3_NS       290
`define ACR_CEIL(t)   (((t) + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_BMAX0_NS       2000
`define ACR_BMAX1_NS       2500
`define ACR_BMAX2_NS       3500
`define ACR_BMAX3_NS       5750
`endif

// >>> verilog/acr_pkg.sv
// Types of the conversion and readout sequencer
package acr_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_CONV = 3'h1,
    S_DROP = 3'h2,
    S_GAP  = 3'h3,
    S_XFER = 3'h4,
    S_END  = 3'h5
  } acr_state_type;
  typedef enum logic [1:0] {
    X_IDLE  = 2'h0,
    X_LEAD  = 2'h1,
    X_SHIFT = 2'h2,
    X_TAIL  = 2'h3
  } acr_xph_type;
  typedef struct packed {
    logic       port_style_select;
    logic       clock_source_select;
    logic       read_during_conv;
    logic [1:0] shift_clock_divider;
  } acr_mode_type;
  typedef struct packed {
    logic shift_clk;
    logic frame;
    logic data;
  } acr_ser_type;
endpackage

// >>> verilog/acr_conv_readout.sv
// Conversion sequencer with parallel and serial result readout
`include "acr_consts.svh"
module acr_conv_readout
  import acr_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  conversion_start_n,
  input  wire acr_mode_type          mode,
  input  wire logic                  port_select_n,
  input  wire logic                  read_n,
  input  wire logic                  ext_shift_clk,
  input  wire logic [`ACR_BITS-1:0]  conv_result,
  output logic                       busy,
  output logic [`ACR_BITS-1:0]       par_data,
  output logic                       par_data_oe,
  output acr_ser_type                ser_o,
  output acr_ser_type                ser_oe
);
  acr_state_type        st_ff;
  acr_xph_type          xph_ff;
  logic [10:0]          cnt_ff;
  logic [`ACR_BITS-1:0] res_ff;
  logic [6:0]           xcnt_ff;
  logic [4:0]           bit_ff;
  logic [`ACR_BITS-1:0] sreg_ff;
  logic                 busy_ff, start_prev_ff, res_valid_ff, rel_ff;
  logic                 sclk_ff, frame_ff, ext_prev_ff;
  logic                 serial, master, rac_mode, rdc_master;
  logic                 start_ok, lat, go, bus_req, ext_rise;
  logic [1:0]           code_eff;

  // Shift clock half period in cycles; each code doubles the period
  function automatic logic [6:0] half_cyc(input logic [1:0] c);
    half_cyc = 7'(`ACR_HALF(`ACR_PER0_NS)) << c;
  endfunction

  // Frame to first shift edge in cycles
  function automatic logic [6:0] lead_cyc(input logic [1:0] c);
    lead_cyc = (c == 2'h0) ? 7'(`ACR_CEIL(`ACR_LEAD0_NS))
                           : 7'(`ACR_CEIL(`ACR_LEADN_NS));
  endfunction

  // Last shift edge to frame end in cycles
  function automatic logic [6:0] tail_cyc(input logic [1:0] c);
    unique case (c)
      2'h0: tail_cyc = 7'(`ACR_CEIL(`ACR_TAIL0_NS));
      2'h1: tail_cyc = 7'(`ACR_CEIL(`ACR_TAIL1_NS));
      2'h2: tail_cyc = 7'(`ACR_CEIL(`ACR_TAIL2_NS));
      2'h3: tail_cyc = 7'(`ACR_CEIL(`ACR_TAIL3_NS));
    endcase
  endfunction

  // Longest busy in cycles per divider code
  function automatic logic [10:0] bmax_cyc(input logic [1:0] c);
    unique case (c)
      2'h0: bmax_cyc = 11'(`ACR_BMAX0_NS / `ACR_CLK_NS);
      2'h1: bmax_cyc = 11'(`ACR_BMAX1_NS / `ACR_CLK_NS);
      2'h2: bmax_cyc = 11'(`ACR_BMAX2_NS / `ACR_CLK_NS);
      2'h3: bmax_cyc = 11'(`ACR_BMAX3_NS / `ACR_CLK_NS);
    endcase
  endfunction

  // Mode decode and strobes
  assign serial     = mode.port_style_select;
  assign master     = serial & ~mode.clock_source_select;
  assign rac_mode   = master & ~mode.read_during_conv;
  assign rdc_master = master & mode.read_during_conv;
  assign code_eff   = rac_mode ? mode.shift_clock_divider : 2'h0;
  assign start_ok   = start_prev_ff & ~conversion_start_n &
                      (st_ff == S_IDLE);
  assign lat        = (st_ff == S_CONV) &&
                      (cnt_ff == 11'(`ACR_CONV_CYC - 1));
  assign go         = ((st_ff == S_GAP) &&
                       (cnt_ff == 11'(`ACR_FRAME_CYC - 1))) ||
                      (start_ok & rdc_master & (xph_ff == X_IDLE));
  assign bus_req    = ~serial & ~read_n & ~port_select_n;
  assign ext_rise   = ext_shift_clk & ~ext_prev_ff;

  // Input edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_prev_ff <= 1'b1;
      ext_prev_ff   <= 1'b0;
    end else begin
      start_prev_ff <= conversion_start_n;
      ext_prev_ff   <= ext_shift_clk;
    end
  end

  // Conversion sequencer and busy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff   <= S_IDLE;
      cnt_ff  <= 11'h000;
      busy_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        S_IDLE: if (start_ok) begin
          st_ff   <= S_CONV;
          cnt_ff  <= 11'h000;
          busy_ff <= 1'b1;
        end
        S_CONV: if (lat) begin
          st_ff  <= rac_mode ? S_GAP : S_DROP;
          cnt_ff <= rac_mode ? cnt_ff + 11'h001 : 11'h000;
        end else begin
          cnt_ff <= cnt_ff + 11'h001;
        end
        S_DROP: if (cnt_ff == 11'(`ACR_DVB_CYC - 1)) begin
          st_ff   <= S_IDLE;
          busy_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff + 11'h001;
        end
        S_GAP: if (go) begin
          st_ff  <= S_XFER;
          cnt_ff <= 11'h000;
        end else begin
          cnt_ff <= cnt_ff + 11'h001;
        end
        S_XFER: if (xph_ff == X_IDLE) begin
          st_ff  <= S_END;
          cnt_ff <= 11'h000;
        end
        S_END: if (cnt_ff == 11'(`ACR_END_CYC - 2)) begin
          st_ff   <= S_IDLE;
          busy_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff + 11'h001;
        end
        default: begin
          st_ff   <= S_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  // Result capture at end of conversion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_ff       <= 16'h0000;
      res_valid_ff <= 1'b0;
    end else if (lat) begin
      res_ff       <= conv_result;
      res_valid_ff <= 1'b1;
    end else if (start_ok) begin
      res_valid_ff <= 1'b0;
    end
  end

  // Parallel bus hold one cycle after the request ends
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rel_ff <= 1'b0;
    end else begin
      rel_ff <= bus_req;
    end
  end

  // Serial transfer engine, master and slave
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xph_ff   <= X_IDLE;
      xcnt_ff  <= 7'h00;
      bit_ff   <= 5'h00;
      sreg_ff  <= 16'h0000;
      sclk_ff  <= 1'b0;
      frame_ff <= 1'b0;
    end else if (go) begin
      xph_ff   <= X_LEAD;
      xcnt_ff  <= 7'h00;
      bit_ff   <= 5'h00;
      sreg_ff  <= res_ff;
      frame_ff <= 1'b1;
    end else begin
      unique case (xph_ff)
        X_IDLE: if (lat & ~master) begin
          sreg_ff <= conv_result;
        end else if (ext_rise & serial & ~master) begin
          sreg_ff <= {sreg_ff[`ACR_BITS-2:0], 1'b0};
        end
        X_LEAD: if (xcnt_ff == lead_cyc(code_eff) - 7'h01) begin
          xph_ff  <= X_SHIFT;
          xcnt_ff <= 7'h00;
          sclk_ff <= 1'b1;
        end else begin
          xcnt_ff <= xcnt_ff + 7'h01;
        end
        X_SHIFT: if (xcnt_ff == half_cyc(code_eff) - 7'h01) begin
          xcnt_ff <= 7'h00;
          sclk_ff <= ~sclk_ff;
          if (sclk_ff) begin
            bit_ff <= bit_ff + 5'h01;
            if (bit_ff == 5'(`ACR_BITS - 1)) begin
              xph_ff <= X_TAIL;
            end else begin
              sreg_ff <= {sreg_ff[`ACR_BITS-2:0], 1'b0};
            end
          end
        end else begin
          xcnt_ff <= xcnt_ff + 7'h01;
        end
        X_TAIL: if (xcnt_ff == tail_cyc(code_eff) - 7'h01) begin
          xph_ff   <= X_IDLE;
          frame_ff <= 1'b0;
        end else begin
          xcnt_ff <= xcnt_ff + 7'h01;
        end
      endcase
    end
  end

  // Pin drivers and enables
  assign busy             = busy_ff;
  assign par_data         = res_ff;
  assign par_data_oe      = ~serial & (bus_req | rel_ff);
  assign ser_o.shift_clk  = sclk_ff;
  assign ser_o.frame      = frame_ff;
  assign ser_o.data       = sreg_ff[`ACR_BITS-1];
  assign ser_oe.shift_clk = master & ~port_select_n;
  assign ser_oe.frame     = master & ~port_select_n;
  assign ser_oe.data      = serial & ~port_select_n;

  // Checker helpers: run lengths of busy, clock high and clock low
  logic [10:0] busy_len_ff;
  logic [6:0]  hi_len_ff;
  logic [6:0]  lo_len_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_len_ff <= 11'h000;
      hi_len_ff   <= 7'h00;
      lo_len_ff   <= 7'h00;
    end else begin
      busy_len_ff <= busy_ff ? busy_len_ff + 11'h001 : 11'h000;
      hi_len_ff   <= sclk_ff ? hi_len_ff + 7'h01 : 7'h00;
      lo_len_ff   <= (sclk_ff || lo_len_ff == 7'h7F) ? 7'h00
                                                     : lo_len_ff + 7'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence busy_through_5;
    busy_ff [*5];
  endsequence

  a_busy_short: assert property (start_ok && !rac_mode |->
    ##[1:250] !busy_ff) else $error("busy too long");
  a_par_valid: assert property (start_ok && !serial |->
    ##[1:250] res_valid_ff) else $error("result late");
  a_data_before: assert property ($fell(busy_ff) |->
    $past(res_valid_ff, 3)) else $error("data not ahead of busy");
  a_bus_release: assert property ($fell(bus_req) ##1 !bus_req
    |-> !par_data_oe) else $error("bus not released");
  a_frame_rise: assert property (start_ok && rac_mode |->
    ##251 $rose(frame_ff) && res_valid_ff) else $error("frame timing");
  a_busy_tail: assert property ($fell(frame_ff) && rac_mode |->
    busy_through_5 ##1 !busy_ff) else $error("busy tail wrong");
  a_sclk_period: assert property ($fell(sclk_ff) |->
    hi_len_ff == half_cyc(code_eff)) else $error("clock period");
  a_busy_width: assert property (busy_ff && rac_mode |->
    busy_len_ff < bmax_cyc(code_eff)) else $error("busy too wide");
  a_frame_lead: assert property ($rose(frame_ff) && code_eff != 2'h0
    |-> !sclk_ff [*4]) else $error("first edge early");
  a_frame_hold: assert property ($fell(frame_ff) |->
    lo_len_ff >= tail_cyc(code_eff)) else $error("frame tail short");
  a_rdc_fast: assert property ($fell(sclk_ff) && rdc_master |->
    hi_len_ff == 7'(`ACR_HALF(`ACR_PER0_NS))) else $error("rdc rate");
  a_cs_enable: assert property (!port_select_n && master |->
    ser_oe.frame && ser_oe.shift_clk && ser_oe.data)
    else $error("serial not enabled");
  a_cs_float: assert property (port_select_n |->
    ser_oe == 3'h0) else $error("serial not floated");
endmodule

// >>> dv/acr_host_model.sv
// Host controller model: starts conversions and reads serial words
module acr_host_model
  import acr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire acr_ser_type ser_o,
  output logic             start_n,
  output logic             ext_clk,
  output logic [15:0]      word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sc_q;
  logic ek_q;

  // Idle levels; the external shift clock stands low outside slave reads
  initial begin
    start_n = 1'b1;
    ext_clk = 1'b0;
  end

  // Shift in on a rising internal clock in frame or a rising host clock
  always @(posedge clk) begin
    {sc_q, ek_q} <= {ser_o.shift_clk, ext_clk};
    if ((ser_o.frame && ser_o.shift_clk && !sc_q) || (ext_clk && !ek_q))
      word <= {word[14:0], ser_o.data};
  end

  // Start pulse once the previous conversion has ended, or after 3000 cycles if busy stays high
  task automatic convert();
    for (int n = 0; n < 3000 && busy; n++) @(negedge clk);
    start_n = 1'b0;
    repeat (2) @(negedge clk);
    start_n = 1'b1;
  endtask

  // Sixteen host clocks of 30 ns; each rising edge reads one bit, the first before any shift
  task automatic slave_read();
    repeat (16) begin
      ext_clk = 1'b1;
      repeat (3) @(negedge clk);
      ext_clk = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
endmodule

// >>> dv/acr_conv_readout_test.sv
// Testbench of the conversion and readout sequencer
module acr_conv_readout_test
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clk, rst_n, port_select_n, read_n, busy, par_data_oe;
  logic         start_n, ext_clk, pst, pb, pf, ps;
  logic  [15:0] conv_result, par_data, word, ppd;
  acr_mode_type mode;
  acr_ser_type  ser_o, ser_oe;
  int           fails, n_compared, seed, cyc, prev, last, nsc, per;
  int           t_st, t_fr, t_fe, t_be, t_pd, t_r, t_r1, t_fl;
  int           tail[4] = '{1, 11, 26, 58};
  int           bmax[4] = '{400, 500, 700, 1150};

  acr_conv_readout acr_conv_readout_i (.clk(clk), .rst_n(rst_n),
    .conversion_start_n(start_n), .mode(mode),
    .port_select_n(port_select_n), .read_n(read_n), .ext_shift_clk(ext_clk),
    .conv_result(conv_result), .busy(busy), .par_data(par_data),
    .par_data_oe(par_data_oe), .ser_o(ser_o), .ser_oe(ser_oe));
  acr_host_model acr_host_model_i (.clk(clk), .busy(busy), .ser_o(ser_o),
    .start_n(start_n), .ext_clk(ext_clk), .word(word));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Event times seen at each rising edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    {pst, pb, pf, ps} <= {start_n, busy, ser_o.frame, ser_o.shift_clk};
    ppd <= par_data;
    if (pst && !start_n && !busy) t_st <= cyc;
    if (par_data !== ppd) t_pd <= cyc;
    if (pb && !busy) t_be <= cyc;
    if (pf && !ser_o.frame) t_fe <= cyc;
    if (ps && !ser_o.shift_clk) t_fl <= cyc;
    if (!pf && ser_o.frame) begin
      t_fr <= cyc;
      nsc <= 0;
    end else if (!ps && ser_o.shift_clk) begin
      nsc <= nsc + 1;
      per <= cyc - t_r;
      t_r <= cyc;
      if (nsc == 0) t_r1 <= cyc;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One conversion with a fresh random result, then wait for busy low
  task automatic conv(input acr_mode_type m);
    int n;
    mode = m;
    conv_result = 16'($random(seed));
    prev = last;
    last = conv_result;
    acr_host_model_i.convert();
    for (n = 0; n < 3000 && busy; n++) @(negedge clk);
    if (busy) begin
      fails++;
      wrap_up();
    end
    repeat (3) @(negedge clk);
  endtask

  initial begin
    {fails, n_compared, cyc, last} = '0;
    seed = 32'h3028;
    {rst_n, read_n, port_select_n} = 3'b010;
    mode = '0;
    conv_result = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    // Parallel conversions back to back, each read over the bus
    repeat (2) begin
      conv(5'h00);
      check("busy width", (t_be - t_st) <= 251, 1);
      check("data delay", (t_pd - t_st) <= 251, 1);
      check("data lead", (t_be - t_pd) >= 3, 1);
      read_n = 1'b0;
      @(negedge clk);
      check("bus oe", par_data_oe, 1);
      check("bus data", par_data, last);
      read_n = 1'b1;
      #1 check("bus hold", par_data_oe, 1);
      repeat (3) @(negedge clk);
      check("bus release", par_data_oe, 0);
    end
    // Master read after conversion at every divider code
    read_n = 1'b0;
    for (int c = 0; c < 4; c++) begin
      conv({3'b100, 2'(c)});
      check("word", word, last);
      check("bits", nsc, 16);
      check("period", per, 6 << c);
      check("frame delay", (t_fr - t_st) inside {[245:255]}, 1);
      check("lead", (t_r1 - t_fr) >= (c > 0 ? 4 : 1), 1);
      check("tail", (t_fe - t_fl) >= tail[c], 1);
      check("busy end", (t_be - t_fe) inside {[4:6]}, 1);
      check("busy max", (t_be - t_st) <= bmax[c], 1);
    end
    check("serial bus oe", par_data_oe, 0);
    read_n = 1'b1;
    check("sel on", ser_oe, 3'b111);
    port_select_n = 1'b1;
    #1 check("sel off", ser_oe, 3'b000);
    @(negedge clk) port_select_n = 1'b0;
    // Read during conversion ignores the slowest divider code
    conv({3'b101, 2'b11});
    check("rdc word", word, prev);
    check("rdc period", per, 6);
    // Slave read clocked by the host
    conv({3'b110, 2'(seed)});
    check("slave oe", ser_oe, 3'b001);
    acr_host_model_i.slave_read();
    check("slave word", word, last);
    wrap_up();
  end
endmodule
